// ===== rtl/vlb_params.svh
`ifndef VLB_PARAMS_SVH
`define VLB_PARAMS_SVH

// System clock period and bus clock period, in ns
`define VLB_SYS_PERIOD_NS 20
`define VLB_LOCAL_BUS_CLK_PERIOD_NS 160
// Half bus clock in system cycles, made by the host divider
`define VLB_LOCAL_BUS_CLK_HALF_CYC ((`VLB_LOCAL_BUS_CLK_PERIOD_NS / `VLB_SYS_PERIOD_NS) / 2)

// Default I/O decode base, compared against address bits 15 down to 4
`define VLB_BASE_ADDR 12'h030
// Word index, from address bits 3 down to 2, of the packet data port
`define VLB_DATA_PORT_IDX 2'h2
// Reset value of the small register window
`define VLB_REG_RST 32'h0000_0000

// Byte-enable patterns, active low, bit 0 is byte lane 0
`define VLB_BE_DWORD 4'h0
`define VLB_BE_LOW 4'h3
`define VLB_BE_HIGH 4'hC
`define VLB_BE_BYTE0 4'hE
`define VLB_BE_BYTE1 4'hD
`define VLB_BE_BYTE2 4'hB
`define VLB_BE_BYTE3 4'h7
`define VLB_LANES_ALL 4'hF
`define VLB_LANES_NONE 4'h0

// Host gives up on a cycle after this many bus clocks without ready
`define VLB_WAIT_LIMIT 8'h10

`endif

// ===== rtl/vlb_pkg.sv
package vlb_pkg;
  `include "vlb_params.svh"

  // Device cycle tracker
  typedef enum logic [0:0] {DEV_IDLE, DEV_RTN} vlb_dev_state_t;

  // Host cycle sequencer
  typedef enum logic [2:0] {HST_IDLE, HST_ADS, HST_WAIT, HST_ACK, HST_RTN} vlb_host_state_t;

  // Active byte lanes for a byte-enable pattern; undefined patterns select none
  function automatic logic [3:0] vlb_lanes(input logic [3:0] be_n);
    case (be_n)
      `VLB_BE_DWORD, `VLB_BE_LOW, `VLB_BE_HIGH: vlb_lanes = ~be_n;
      `VLB_BE_BYTE0, `VLB_BE_BYTE1, `VLB_BE_BYTE2, `VLB_BE_BYTE3: vlb_lanes = ~be_n;
      default: vlb_lanes = `VLB_LANES_NONE;
    endcase
  endfunction : vlb_lanes
endpackage : vlb_pkg

// ===== rtl/vlb_if.sv
`timescale 1ns/1ns
interface vlb_if;
  logic local_bus_clk;
  logic [15:2] addr;
  logic a1;
  logic io_qualifier_n;
  logic write_not_read;
  logic [3:0] byte_en_n;
  logic addr_strobe_n;
  logic cycle_qual_n;
  logic ready_return_n;
  logic sync_ready_n;
  logic local_device_sel_n;
  logic [31:0] host_data;
  logic [3:0] host_data_oe_n;
  logic [31:0] dev_data;
  logic [3:0] dev_data_oe_n;
  wire [31:0] data;

  // Resolve each byte lane from the two enables; a lane nobody drives reads all ones
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign data[8*i +: 8] = !dev_data_oe_n[i] ? dev_data[8*i +: 8] :
                            !host_data_oe_n[i] ? host_data[8*i +: 8] : 8'hFF;
  end

  modport dev (
    input local_bus_clk, addr, io_qualifier_n, write_not_read, byte_en_n,
    input addr_strobe_n, cycle_qual_n, ready_return_n, data,
    output sync_ready_n, local_device_sel_n, dev_data, dev_data_oe_n
  );

  modport host (
    output local_bus_clk, addr, a1, io_qualifier_n, write_not_read, byte_en_n,
    output addr_strobe_n, cycle_qual_n, ready_return_n, host_data, host_data_oe_n,
    input sync_ready_n, local_device_sel_n, data
  );
endinterface : vlb_if

// ===== rtl/vlb_dev.sv
`timescale 1ns/1ns
`include "vlb_params.svh"
// Behaviour
// - host uses byte/word for non-data registers; a dword there is still performed and flagged on width_err_out
// - data port takes byte, word, dword
// - address transparent while strobe low, else latched
// - I/O qualifier low enables decode, latched
// - direction sampled at first qualified bus edge
// - direction high for write, low read
// - byte enables transparent, latched at strobe rise
// - cycle qualifier is strobe delayed one clock
// - all steps on rising bus clock edges; the host drives its outputs on falling edges
// - dword, low word, high word patterns
// - unselected lanes undriven on read, ignored on write
// - A1 tied low; enables 2/3 pick word
// - select output on address match, qualifier low
// - external logic builds bus ready from ready
// - board inverts bus reset onto device reset
module vlb_dev
  import vlb_pkg::*;
#(
  parameter logic [11:0] BASE_ADDR = `VLB_BASE_ADDR
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  vlb_if.dev bus,
  input wire logic [31:0] port_rdata_in,
  output logic [31:0] port_wdata_out,
  output logic [3:0] port_lanes_out,
  output logic port_wr_out,
  output logic port_rd_out,
  output logic width_err_out,
  output logic busy_out
);

  // Pin synchroniser layout: one vector, two flip-flop stages
  localparam int SYNC_W = 56;
  // Idle pin levels, so no false strobe or qualifier shows right after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'h0, 3'h7, 1'h0, 1'h1, 4'hF, 14'h0000, 32'h0000_0000};
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic local_bus_clk_d;
  wire [SYNC_W-1:0] pins_raw;

  // Latched address phase
  logic [15:2] lat_addr;
  logic lat_io_n;
  logic [3:0] lat_be_n;

  // Cycle state
  vlb_dev_state_t state;
  vlb_dev_state_t next_state;
  logic [31:0] regs [4];

  // Gather every pin coming from the bus into one vector
  assign pins_raw = {bus.local_bus_clk, bus.addr_strobe_n, bus.cycle_qual_n, bus.ready_return_n,
                     bus.write_not_read, bus.io_qualifier_n, bus.byte_en_n, bus.addr, bus.data};

  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else if (clk_en_in) begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  // Synchronised pin views
  wire p_local_bus_clk = sync2[55];
  wire p_strobe_n = sync2[54];
  wire p_cq_n = sync2[53];
  wire p_rtn_n = sync2[52];
  wire p_wnr = sync2[51];
  wire p_io_n = sync2[50];
  wire [3:0] p_be_n = sync2[49:46];
  wire [15:2] p_addr = sync2[45:32];
  wire [31:0] p_data = sync2[31:0];

  // Bus clock edge detect on the synchronised copy
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      local_bus_clk_d <= 1'b0;
    end else if (clk_en_in) begin
      local_bus_clk_d <= p_local_bus_clk;
    end
  end

  wire local_bus_clk_rise = p_local_bus_clk & ~local_bus_clk_d;

  // Hold address, qualifier and enables while the strobe is high
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lat_addr <= '0;
      lat_io_n <= 1'b1;
      lat_be_n <= `VLB_LANES_ALL;
    end else if (clk_en_in && !p_strobe_n) begin
      lat_addr <= p_addr;
      lat_io_n <= p_io_n;
      lat_be_n <= p_be_n;
    end
  end

  // Transparent view: live pins while strobe low, latched copy afterwards
  wire [15:2] cur_addr = p_strobe_n ? lat_addr : p_addr;
  wire cur_io_n = p_strobe_n ? lat_io_n : p_io_n;
  wire [3:0] cur_be_n = p_strobe_n ? lat_be_n : p_be_n;

  // Decode; A1 is ignored, the upper/lower word comes from enables 2 and 3
  wire sel_hit = (cur_addr[15:4] == BASE_ADDR) && !cur_io_n;
  wire [1:0] word_idx = cur_addr[3:2];
  wire [3:0] lanes = vlb_lanes(cur_be_n);
  wire is_port = word_idx == `VLB_DATA_PORT_IDX;
  wire full_width = lanes == `VLB_LANES_ALL;

  // Start on the first bus edge with the qualifier low, end on ready return
  wire start_cyc = (state == DEV_IDLE) && local_bus_clk_rise && !p_cq_n && sel_hit;
  wire end_cyc = (state == DEV_RTN) && local_bus_clk_rise && !p_rtn_n;
  wire [31:0] rd_word = is_port ? port_rdata_in : regs[word_idx];

  // Next-state selection
  always_comb begin
    next_state = state;
    case (state)
      DEV_IDLE: begin
        if (start_cyc) begin
          next_state = DEV_RTN;
        end
      end
      DEV_RTN: begin
        if (end_cyc) begin
          next_state = DEV_IDLE;
        end
      end
      default: next_state = DEV_IDLE;
    endcase
  end

  // State register and busy flag
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= DEV_IDLE;
      busy_out <= 1'b0;
    end else if (clk_en_in) begin
      state <= next_state;
      busy_out <= next_state == DEV_RTN;
    end
  end

  // Select output, registered each system cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus.local_device_sel_n <= 1'b1;
    end else if (clk_en_in) begin
      bus.local_device_sel_n <= ~sel_hit;
    end
  end

  // Ready and read drive: asserted at start, released on ready return
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus.sync_ready_n <= 1'b1;
      bus.dev_data <= '0;
      bus.dev_data_oe_n <= `VLB_LANES_ALL;
    end else if (clk_en_in) begin
      if (start_cyc) begin
        bus.sync_ready_n <= 1'b0;
        if (!p_wnr) begin
          bus.dev_data <= rd_word;
          bus.dev_data_oe_n <= ~lanes;
        end
      end else if (end_cyc) begin
        bus.sync_ready_n <= 1'b1;
        bus.dev_data_oe_n <= `VLB_LANES_ALL;
      end
    end
  end

  // Register window writes, only enabled lanes change
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int w = 0; w < 4; w++) begin
        regs[w] <= `VLB_REG_RST;
      end
    end else if (clk_en_in && start_cyc && p_wnr && !is_port) begin
      for (int i = 0; i < 4; i++) begin
        if (lanes[i]) begin
          regs[word_idx][8*i +: 8] <= p_data[8*i +: 8];
        end
      end
    end
  end

  // Data port strobes to the user side, any width accepted
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_wdata_out <= '0;
      port_lanes_out <= `VLB_LANES_NONE;
      port_wr_out <= 1'b0;
      port_rd_out <= 1'b0;
    end else if (clk_en_in) begin
      port_wr_out <= start_cyc && is_port && p_wnr;
      port_rd_out <= start_cyc && is_port && !p_wnr;
      if (start_cyc && is_port) begin
        port_lanes_out <= lanes;
        port_wdata_out <= p_data & {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
      end
    end
  end

  // Flag a doubleword access to a register other than the data port
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      width_err_out <= 1'b0;
    end else if (clk_en_in) begin
      width_err_out <= start_cyc && !is_port && full_width;
    end
  end

endmodule : vlb_dev

// ===== rtl/vlb_host.sv
`timescale 1ns/1ns
`include "vlb_params.svh"
module vlb_host
  import vlb_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  vlb_if.host bus,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [15:2] req_addr_in,
  input wire logic req_io_n_in,
  input wire logic [3:0] req_be_n_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic timeout_out,
  output logic [31:0] rdata_out
);

  localparam logic [7:0] HALF_CYC = 8'(`VLB_LOCAL_BUS_CLK_HALF_CYC);
  logic [7:0] div_cnt;
  logic [7:0] wait_cnt;
  logic got_ready;
  vlb_host_state_t state;
  logic [32:0] pin_s1;
  logic [32:0] pin_s2;

  // Device pins seen only through the second synchroniser stage
  wire s_ready_n = pin_s2[32];
  wire [31:0] s_data = pin_s2[31:0];

  // Two-stage synchroniser for ready and data, idle levels in reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
    end else if (clk_en_in) begin
      pin_s1 <= {bus.sync_ready_n, bus.data};
      pin_s2 <= pin_s1;
    end
  end

  // Bus clock divider; outputs change on falls, inputs sampled on rises
  wire tick = div_cnt == HALF_CYC - 8'h01;
  wire fall = tick && bus.local_bus_clk;
  wire rise = tick && !bus.local_bus_clk;
  wire [3:0] lanes = vlb_lanes(bus.byte_en_n);
  wire [31:0] lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};

  // Divider counter and bus clock output
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt <= 8'h00;
      bus.local_bus_clk <= 1'b0;
    end else if (clk_en_in) begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      bus.local_bus_clk <= bus.local_bus_clk ^ tick;
    end
  end

  // Sample ready and read data at each bus clock rise while in HST_WAIT
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      got_ready <= 1'b0;
      wait_cnt <= 8'h00;
      rdata_out <= '0;
    end else if (clk_en_in) begin
      if (state != HST_WAIT) begin
        got_ready <= 1'b0;
        wait_cnt <= 8'h00;
      end else if (rise) begin
        got_ready <= !s_ready_n;
        wait_cnt <= wait_cnt + 8'h01;
        if (!s_ready_n && !bus.write_not_read) begin
          rdata_out <= s_data & lane_mask;
        end
      end
    end
  end

  // Cycle sequencer, one step per bus clock fall
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= HST_IDLE;
      bus.addr <= '0;
      bus.a1 <= 1'b0;
      bus.io_qualifier_n <= 1'b1;
      bus.write_not_read <= 1'b0;
      bus.byte_en_n <= `VLB_LANES_ALL;
      bus.addr_strobe_n <= 1'b1;
      bus.cycle_qual_n <= 1'b1;
      bus.ready_return_n <= 1'b1;
      bus.host_data <= '0;
      bus.host_data_oe_n <= `VLB_LANES_ALL;
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      timeout_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      timeout_out <= 1'b0;
      req_ready_out <= (state == HST_IDLE) && fall && !req_valid_in ? 1'b0 : req_ready_out;
      case (state)
        HST_IDLE: begin
          req_ready_out <= 1'b1;
          if (fall && req_valid_in) begin
            req_ready_out <= 1'b0;
            bus.addr <= req_addr_in;
            bus.a1 <= 1'b0;
            bus.io_qualifier_n <= req_io_n_in;
            bus.write_not_read <= req_write_in;
            bus.byte_en_n <= req_be_n_in;
            bus.addr_strobe_n <= 1'b0;
            bus.host_data <= req_wdata_in;
            state <= HST_ADS;
          end
        end
        HST_ADS: begin
          if (fall) begin
            bus.addr_strobe_n <= 1'b1;
            bus.cycle_qual_n <= 1'b0;
            if (bus.write_not_read) begin
              bus.host_data_oe_n <= ~lanes;
            end
            state <= HST_WAIT;
          end
        end
        HST_WAIT: begin
          if (fall && got_ready) begin
            bus.ready_return_n <= 1'b0;
            bus.cycle_qual_n <= 1'b1;
            bus.host_data_oe_n <= `VLB_LANES_ALL;
            state <= HST_RTN;
          end else if (fall && wait_cnt >= `VLB_WAIT_LIMIT) begin
            bus.cycle_qual_n <= 1'b1;
            bus.host_data_oe_n <= `VLB_LANES_ALL;
            timeout_out <= 1'b1;
            done_out <= 1'b1;
            state <= HST_IDLE;
          end
        end
        HST_RTN: begin
          if (fall) begin
            bus.ready_return_n <= 1'b1;
            done_out <= 1'b1;
            state <= HST_IDLE;
          end
        end
        default: state <= HST_IDLE;
      endcase
    end
  end

endmodule : vlb_host

// ===== tb/vlb_props.sv
`timescale 1ns/1ns
module vlb_props #(
  parameter logic [11:0] BASE = 12'h030
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:2] addr,
  input wire logic a1,
  input wire logic addr_strobe_n,
  input wire logic io_qualifier_n,
  input wire logic write_not_read,
  input wire logic [3:0] byte_en_n,
  input wire logic cycle_qual_n,
  input wire logic ready_return_n,
  input wire logic sync_ready_n,
  input wire logic local_device_sel_n,
  input wire logic [3:0] dev_data_oe_n
);
  // Address match and defined enable patterns
  wire hit = (addr[15:4] == BASE) && !io_qualifier_n;
  wire defined_be = byte_en_n inside {4'h0, 4'h3, 4'hC, 4'hE, 4'hD, 4'hB, 4'h7};

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Cycle start and ready release steps
  sequence qual_start;
    $fell(cycle_qual_n) && !local_device_sel_n;
  endsequence
  sequence ready_gone;
    ##[1:16] sync_ready_n;
  endsequence

  sel_on_hit_a: assert property (hit [*5] |-> !local_device_sel_n)
    else $error("select not asserted on matching address");
  sel_off_miss_a: assert property (!hit [*5] |-> local_device_sel_n)
    else $error("select asserted without a match");
  ready_after_qual_a: assert property (qual_start |-> ##[4:16] !sync_ready_n)
    else $error("no ready after qualified cycle start");
  ready_release_a: assert property ($fell(ready_return_n) |-> ready_gone)
    else $error("ready not released after ready return");
  ready_hold_a: assert property (!sync_ready_n && !cycle_qual_n |=> !sync_ready_n)
    else $error("ready dropped before ready return");
  ready_needs_sel_a: assert property ($fell(sync_ready_n) |-> !local_device_sel_n)
    else $error("ready without select");
  read_lanes_a: assert property (!sync_ready_n && !write_not_read && defined_be |-> dev_data_oe_n == byte_en_n)
    else $error("read lanes differ from enables");
  lane_unselected_a: assert property (dev_data_oe_n != 4'hF |-> (~dev_data_oe_n & byte_en_n) == 4'h0)
    else $error("unselected lane driven");
  no_drive_write_a: assert property (write_not_read && !cycle_qual_n |-> dev_data_oe_n == 4'hF)
    else $error("device drives data during write");
  strobe_to_qual_a: assert property ($rose(addr_strobe_n) |-> $fell(cycle_qual_n))
    else $error("qualifier not one bus clock after strobe");
  addr_bit1_low_a: assert property (!a1)
    else $error("address bit 1 not held low");
endmodule : vlb_props

// ===== tb/vl_bus_slave_interface_tb_top.sv
`timescale 1ns/1ns
module vl_bus_slave_interface_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, req_write, req_io_n, done, timeout, pwr, prd, werr, rdy, busy;
  int werr_exp = 0;
  int werr_seen = 0;
  logic [15:2] req_addr;
  logic [3:0] req_be_n, plane;
  logic [31:0] req_wdata, prd_in, pwd, rdata;
  logic [31:0] regs [4];
  logic [33:0] hq[$];
  logic [36:0] dq[$];
  logic [31:0] seed = 32'h0000_ED66;
  logic [3:0] pats [7] = '{4'h0, 4'h3, 4'hC, 4'hE, 4'hD, 4'hB, 4'h7};
  int miscompares = 0;
  int n_tests = 0;

  // Free running system clock
  initial forever #10 clk_sys = ~clk_sys;

  vlb_if bus();
  vlb_host i_vlb_host(.clk_sys_in(clk_sys), .rst_n_in(rst_n), .clk_en_in(1'b1), .bus(bus),
    .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr), .req_io_n_in(req_io_n),
    .req_be_n_in(req_be_n), .req_wdata_in(req_wdata), .req_ready_out(rdy), .done_out(done),
    .timeout_out(timeout), .rdata_out(rdata));
  vlb_dev i_vlb_dev(.clk_sys_in(clk_sys), .rst_n_in(rst_n), .clk_en_in(1'b1), .bus(bus),
    .port_rdata_in(prd_in), .port_wdata_out(pwd), .port_lanes_out(plane), .port_wr_out(pwr),
    .port_rd_out(prd), .width_err_out(werr), .busy_out(busy));
  vlb_props #(.BASE(12'h030)) i_vlb_props(.clk_sys_in(clk_sys), .rst_n_in(rst_n), .addr(bus.addr),
    .a1(bus.a1), .addr_strobe_n(bus.addr_strobe_n),
    .io_qualifier_n(bus.io_qualifier_n), .write_not_read(bus.write_not_read), .byte_en_n(bus.byte_en_n),
    .cycle_qual_n(bus.cycle_qual_n), .ready_return_n(bus.ready_return_n), .sync_ready_n(bus.sync_ready_n),
    .local_device_sel_n(bus.local_device_sel_n), .dev_data_oe_n(bus.dev_data_oe_n));

  // Xorshift source for data values
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Lanes moved by an enable pattern
  function automatic logic [3:0] lanes_of(input logic [3:0] be);
    return (be inside {4'h0, 4'h3, 4'hC, 4'hE, 4'hD, 4'hB, 4'h7}) ? ~be : 4'h0;
  endfunction : lanes_of

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // One host request; expected outcomes go to the queues
  task automatic xfer(input logic wr, input logic [15:2] a, input logic io_n, input logic [3:0] be);
    logic [31:0] d, m;
    logic [3:0] l;
    logic ok;
    int n;
    d = xs();
    l = lanes_of(be);
    m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    ok = (a[15:4] == 12'h030) && !io_n;
    if (ok && a[3:2] != 2'h2 && l == 4'hF) werr_exp++;
    @(negedge clk_sys);
    prd_in = d;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_io_n = io_n;
    req_be_n = be;
    req_wdata = d;
    if (!ok) begin
      hq.push_back({1'b0, 1'b1, 32'h0000_0000});
    end else if (a[3:2] == 2'h2) begin
      dq.push_back({wr, l, wr ? (d & m) : 32'h0000_0000});
      hq.push_back({!wr, 1'b0, d & m});
    end else begin
      if (wr) begin
        regs[a[3:2]] = (regs[a[3:2]] & ~m) | (d & m);
      end
      hq.push_back({!wr, 1'b0, regs[a[3:2]] & m});
    end
    n = 0;
    while (rdy && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (rdy) miscompares++;
    req_valid = 1'b0;
    n = 0;
    while (!rdy && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (!rdy) miscompares++;
  endtask : xfer

  // Monitor: pop the oldest note whenever a result appears
  always @(negedge clk_sys) begin
    logic [33:0] h;
    logic [36:0] e;
    if (rst_n && done) begin
      h = hq.size() ? hq.pop_front() : 'x;
      check("timeout", {31'h0, timeout}, {31'h0, h[32]});
      check("busy", {31'h0, busy}, 32'h0000_0000);
      if (h[33]) check("rdata", rdata, h[31:0]);
    end
    if (rst_n && werr) werr_seen++;
    if (rst_n && (pwr || prd)) begin
      e = dq.size() ? dq.pop_front() : 'x;
      check("direction", {31'h0, pwr}, {31'h0, e[36]});
      check("lanes", {28'h0, plane}, {28'h0, e[35:32]});
      if (e[36]) check("wdata", pwd, e[31:0]);
    end
  end

  // Main sequence
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_io_n = 1'b1;
    req_be_n = 4'hF;
    req_wdata = '0;
    prd_in = '0;
    foreach (regs[k]) regs[k] = 32'h0000_0000;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    foreach (pats[i]) begin
      xfer(1'b1, {12'h030, 2'h2}, 1'b0, pats[i]);
      xfer(1'b0, {12'h030, 2'h2}, 1'b0, pats[i]);
      xfer(1'b1, {12'h030, (i % 3 == 2) ? 2'h3 : 2'(i % 3)}, 1'b0, pats[i]);
      xfer(1'b0, {12'h030, (i % 3 == 2) ? 2'h3 : 2'(i % 3)}, 1'b0, 4'h0);
    end
    // Refused: wrong base, qualifier high, high address bit
    xfer(1'b0, {12'h031, 2'h2}, 1'b0, 4'h0);
    xfer(1'b1, {12'h030, 2'h0}, 1'b1, 4'h0);
    xfer(1'b0, {12'h830, 2'h1}, 1'b0, 4'h3);
    // Reset in mid run clears the window
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (regs[k]) regs[k] = 32'h0000_0000;
    repeat (4) @(negedge clk_sys);
    xfer(1'b0, {12'h030, 2'h1}, 1'b0, 4'h0);
    repeat (20) @(negedge clk_sys);
    check("pending", hq.size() + dq.size(), 32'h0000_0000);
    check("width_err", werr_seen, werr_exp);
    test_done();
  end

  // Watchdog against a hung bus
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule : vl_bus_slave_interface_tb_top
